/* File: hw/dcf_ram.v */
// Storage array of the FIFO: one write port, combinational read port
`timescale 1ns/100ps
`default_nettype none
`include "dcf_map.vh"

module dcf_ram #(
   parameter ADDR_W = `DCF_ADDR_W_DEFAULT,
   parameter DATA_W = `DCF_WORD_W
) (
   input wire clk,
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [DATA_W-1:0] wr_data,
   input wire [ADDR_W-1:0] rd_addr,
   output wire [DATA_W-1:0] rd_data
);

   reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem[rd_addr];

endmodule // dcf_ram

`default_nettype wire

/* File: hw/dcf_thresh.v */
// Bank of four 9-bit threshold registers with a shared sequence position
`timescale 1ns/100ps
`default_nettype none
`include "dcf_map.vh"

module dcf_thresh #(
   parameter DATA_W = `DCF_WORD_W
) (
   input wire clk,
   input wire reset_n,
   input wire wr_stb,
   input wire rd_stb,
   input wire [DATA_W-1:0] wr_data,
   output wire [DATA_W-1:0] rd_data,
   output wire [2*DATA_W-1:0] empty_threshold,
   output wire [2*DATA_W-1:0] full_threshold
);

   reg [1:0] seq_reg;
   wire [DATA_W-1:0] thr_q [0:3];

   // One position for writes and reads; it survives while load is released
   always @(posedge clk) begin
      if (!reset_n) begin
         seq_reg <= `DCF_SEQ_EMPTY_LOW;
      end else if (wr_stb || rd_stb) begin
         seq_reg <= seq_reg + 2'h1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_thr
         reg [DATA_W-1:0] val_reg;
         always @(posedge clk) begin
            if (!reset_n) begin
               val_reg <= ((i % 2) == 0) ? `DCF_THR_LOW_RST : `DCF_THR_HIGH_RST;
            end else if (wr_stb && ({30'h0, seq_reg} == i)) begin
               val_reg <= wr_data;
            end
         end
         assign thr_q[i] = val_reg;
      end
   endgenerate

   assign rd_data = thr_q[seq_reg];
   assign empty_threshold = {thr_q[`DCF_SEQ_EMPTY_HIGH], thr_q[`DCF_SEQ_EMPTY_LOW]};
   assign full_threshold = {thr_q[`DCF_SEQ_FULL_HIGH], thr_q[`DCF_SEQ_FULL_LOW]};

endmodule // dcf_thresh

`default_nettype wire

/* File: hw/dcf_top.v */
// FIFO with empty, full and programmable almost-empty/almost-full flags
`timescale 1ns/100ps
`default_nettype none
`include "dcf_map.vh"

// Operation
// - Storage of 9-bit words, depth 64K or 128K set by parameter.
// - Almost thresholds reset to seven words from each boundary.
// - Empty and full flags both move on rising edges of the one clock sys_clk.
// - A changed flag holds its value at least one clock cycle.
// - Reset empties FIFO, empty flag low, all flags valid during reset.
// - Data outputs are zero after reset is released.
// - Load pin level at reset selects standalone or depth-expansion mode.
// - Write enable low and full flag high stores word, advances pointer.
// - Read enable low and empty flag high presents next word, advances.
// - Output enable is registered onto read_word_oe_n; read_word is always driven.
// - Writes ignored while full flag low; low at full depth.
// - Reads ignored while empty flag low; low when nothing unread.
// - Empty FIFO keeps last validly read word on the outputs.
// - In standalone mode, load and write low store offsets in order, wrapping after four.
// - Offset sequence position survives load going high.
// - In standalone mode, load and read low place next offset register on outputs.
// - Almost-empty low at n or fewer unread words, else high.
// - Almost-full low at depth minus m unread words or more.
// - In standalone mode, replay strobe rewinds read pointer to first location.
// - Flags are recomputed from pointer positions during replay.
module dcf_top #(
   parameter ADDR_W = `DCF_ADDR_W_DEFAULT
) (
   input wire sys_clk,
   input wire reset_n,
   input wire [`DCF_WORD_W-1:0] write_word,
   input wire write_enable_n,
   input wire read_enable_n,
   input wire output_enable_n,
   input wire threshold_load_n,
   input wire replay_strobe,
   output wire [`DCF_WORD_W-1:0] read_word,
   output wire read_word_oe_n,
   output wire empty_flag_n,
   output wire full_flag_n,
   output wire almost_empty_flag_n,
   output wire almost_full_flag_n,
   output wire expansion_mode
);

   localparam DW = `DCF_WORD_W;
   localparam CW = `DCF_CMP_W;
   localparam PW = ADDR_W + 1;
   localparam [CW-1:0] DEPTH_EXT = {{(CW-1){1'b0}}, 1'b1} << ADDR_W;

   // Registered state
   reg [PW-1:0] wr_ptr_reg;
   reg [PW-1:0] rd_ptr_reg;
   reg [DW-1:0] read_word_reg;
   reg read_word_oe_n_reg;
   reg empty_flag_n_reg;
   reg full_flag_n_reg;
   reg almost_empty_flag_n_reg;
   reg almost_full_flag_n_reg;
   reg expansion_reg;

   // Next values
   reg [PW-1:0] wr_ptr_next;
   reg [PW-1:0] rd_ptr_next;
   reg [DW-1:0] read_word_next;
   wire [PW-1:0] count_next;
   wire [CW-1:0] count_ext;
   wire [CW-1:0] n_ext;
   wire [CW-1:0] m_ext;

   // Decoded operations
   wire std_mode;
   wire load_active;
   wire replay_active;
   wire wr_fire;
   wire rd_fire;
   wire thr_wr;
   wire thr_rd;

   wire [DW-1:0] ram_rdata;
   wire [DW-1:0] thr_rdata;
   wire [2*DW-1:0] empty_threshold;
   wire [2*DW-1:0] full_threshold;

   // Load and replay only have meaning in standalone mode
   assign std_mode = ~expansion_reg;
   assign load_active = std_mode & ~threshold_load_n;
   assign replay_active = std_mode & replay_strobe;

   // Data path moves only when no standalone-mode load or replay is active
   assign wr_fire = ~write_enable_n & full_flag_n_reg & ~load_active & ~replay_active;
   assign rd_fire = ~read_enable_n & empty_flag_n_reg & ~load_active & ~replay_active;

   // Offset register access; a simultaneous write and read advances once
   assign thr_wr = load_active & ~write_enable_n;
   assign thr_rd = load_active & ~read_enable_n;

   dcf_ram #(
      .ADDR_W(ADDR_W),
      .DATA_W(DW)
   ) u_ram (
      .clk(sys_clk),
      .wr_en(wr_fire),
      .wr_addr(wr_ptr_reg[ADDR_W-1:0]),
      .wr_data(write_word),
      .rd_addr(rd_ptr_reg[ADDR_W-1:0]),
      .rd_data(ram_rdata)
   );

   dcf_thresh #(
      .DATA_W(DW)
   ) u_thresh (
      .clk(sys_clk),
      .reset_n(reset_n),
      .wr_stb(thr_wr),
      .rd_stb(thr_rd),
      .wr_data(write_word),
      .rd_data(thr_rdata),
      .empty_threshold(empty_threshold),
      .full_threshold(full_threshold)
   );

   // Pointers carry one extra bit so full and empty differ; address wraps
   always @* begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      if (wr_fire) begin
         wr_ptr_next = wr_ptr_reg + {{(PW-1){1'b0}}, 1'b1};
      end
      if (replay_active) begin
         rd_ptr_next = {PW{1'b0}};
      end else if (rd_fire) begin
         rd_ptr_next = rd_ptr_reg + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // Unread words after this edge; replay rewinds so the count is writes so far
   assign count_next = wr_ptr_next - rd_ptr_next;
   assign count_ext = {{(CW-PW){1'b0}}, count_next};
   assign n_ext = {{(CW-2*DW){1'b0}}, empty_threshold};
   assign m_ext = {{(CW-2*DW){1'b0}}, full_threshold};

   // Output register: FIFO word, offset readback, or last value held
   always @* begin
      read_word_next = read_word_reg;
      if (rd_fire) begin
         read_word_next = ram_rdata;
      end else if (thr_rd) begin
         read_word_next = thr_rdata;
      end
   end

   // Mode strap is sampled on every clock edge while reset is held, last sample kept
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         expansion_reg <= threshold_load_n;
      end
   end

   // Pointer and data registers
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_ptr_reg <= {PW{1'b0}};
         rd_ptr_reg <= {PW{1'b0}};
         read_word_reg <= `DCF_READ_WORD_RST;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         read_word_reg <= read_word_next;
      end
   end

   // Output enable is registered so the pin control comes from a flop
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         read_word_oe_n_reg <= 1'b1;
      end else begin
         read_word_oe_n_reg <= output_enable_n;
      end
   end

   // Flags are flops fed from the next count, so each holds a full cycle
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         empty_flag_n_reg <= `DCF_EMPTY_RST;
         almost_empty_flag_n_reg <= `DCF_ALMOST_EMPTY_RST;
         full_flag_n_reg <= `DCF_FULL_RST;
         almost_full_flag_n_reg <= `DCF_ALMOST_FULL_RST;
      end else begin
         // Read-side flags
         empty_flag_n_reg <= (count_ext != {CW{1'b0}});
         almost_empty_flag_n_reg <= (count_ext > n_ext);
         // Write-side flags
         full_flag_n_reg <= (count_ext != DEPTH_EXT);
         almost_full_flag_n_reg <= ((count_ext + m_ext) < DEPTH_EXT);
      end
   end

   assign read_word = read_word_reg;
   assign read_word_oe_n = read_word_oe_n_reg;
   assign empty_flag_n = empty_flag_n_reg;
   assign full_flag_n = full_flag_n_reg;
   assign almost_empty_flag_n = almost_empty_flag_n_reg;
   assign almost_full_flag_n = almost_full_flag_n_reg;
   assign expansion_mode = expansion_reg;

endmodule // dcf_top

`default_nettype wire

/* File: pkg/dcf_map.vh */
// Constants for the dual-port FIFO with programmable flags
`ifndef DCF_MAP_VH
`define DCF_MAP_VH

// Word width of the storage array and the data pins
`define DCF_WORD_W 9
// Default log2 of depth: 16 gives 64K words, 17 gives 128K words
`define DCF_ADDR_W_DEFAULT 16
// Width of the comparison path for flag thresholds
`define DCF_CMP_W 19

// Threshold register sequence positions
`define DCF_SEQ_EMPTY_LOW 2'h0
`define DCF_SEQ_EMPTY_HIGH 2'h1
`define DCF_SEQ_FULL_LOW 2'h2
`define DCF_SEQ_FULL_HIGH 2'h3

// Threshold reset values: seven words from each boundary
`define DCF_THR_LOW_RST 9'h007
`define DCF_THR_HIGH_RST 9'h000

// Flag levels while reset is held
`define DCF_EMPTY_RST 1'b0
`define DCF_ALMOST_EMPTY_RST 1'b0
`define DCF_FULL_RST 1'b1
`define DCF_ALMOST_FULL_RST 1'b1

// Output register value after reset
`define DCF_READ_WORD_RST 9'h000

`endif

/* File: testbench/dcf_agent.sv */
// Writing and reading agent on the far side of the FIFO
`timescale 1ns/100ps
`default_nettype none
module dcf_agent (
   input wire logic sys_clk,
   output var logic [8:0] write_word,
   output var logic write_enable_n,
   output var logic read_enable_n
);
   initial begin
      write_word = 9'h1FF;
      write_enable_n = 1'b1;
      read_enable_n = 1'b1;
   end
   // One transfer: enables held over one taking edge, idle data inverted after
   task automatic op(input logic w, input logic r, input logic [8:0] d);
      @(posedge sys_clk);
      write_enable_n <= !w;
      read_enable_n <= !r;
      write_word <= w ? d : ~write_word;
      @(posedge sys_clk);
      write_enable_n <= 1'b1;
      read_enable_n <= 1'b1;
      write_word <= ~d;
      #1;
   endtask
endmodule // dcf_agent
`default_nettype wire

/* File: testbench/dcf_chk.sv */
// Port-level assertions for the FIFO top module
`timescale 1ns/100ps
`default_nettype none
`include "dcf_map.vh"
module dcf_chk #(
   parameter ADDR_W = `DCF_ADDR_W_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [`DCF_WORD_W-1:0] write_word,
   input wire logic write_enable_n,
   input wire logic read_enable_n,
   input wire logic output_enable_n,
   input wire logic threshold_load_n,
   input wire logic replay_strobe,
   input wire logic [`DCF_WORD_W-1:0] read_word,
   input wire logic read_word_oe_n,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic almost_empty_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic expansion_mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_reset_state: assert property (disable iff (1'b0) !reset_n |=>
      !empty_flag_n && !almost_empty_flag_n && full_flag_n && almost_full_flag_n && read_word == 0)
      else $error("reset state wrong");
   a_write_fills: assert property (!write_enable_n && full_flag_n && threshold_load_n
      && !replay_strobe && !expansion_mode |=> empty_flag_n) else $error("write lost");
   a_full_blocks: assert property (!full_flag_n && !write_enable_n && read_enable_n
      && !replay_strobe |=> !full_flag_n) else $error("write taken while full");
   a_empty_holds: assert property (!empty_flag_n && !read_enable_n && write_enable_n
      && threshold_load_n |=> $stable(read_word)) else $error("read taken while empty");
   a_empty_almost: assert property (!empty_flag_n |-> !almost_empty_flag_n)
      else $error("almost empty high while empty");
   a_full_almost: assert property (!full_flag_n |-> !almost_full_flag_n)
      else $error("almost full high while full");
   a_oe_follows: assert property ($past(reset_n) |-> read_word_oe_n == $past(output_enable_n))
      else $error("output enable not followed");
   a_load_freeze: assert property (!threshold_load_n && !expansion_mode && !replay_strobe
      |=> $stable(empty_flag_n) && $stable(full_flag_n)) else $error("fifo moved under load");
endmodule // dcf_chk
bind dcf_top dcf_chk #(.ADDR_W(ADDR_W)) i_dcf_chk (.*);
`default_nettype wire

/* File: testbench/dual_clock_sync_fifo_flags_tb_top.sv */
// Self-checking bench for the FIFO with programmable flags
`timescale 1ns/100ps
`default_nettype none
module dual_clock_sync_fifo_flags_tb_top;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic output_enable_n = 1'b1;
   logic threshold_load_n = 1'b0;
   logic replay_strobe = 1'b0;
   wire [8:0] write_word;
   wire [8:0] read_word;
   wire write_enable_n, read_enable_n, read_word_oe_n, expansion_mode;
   wire empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
   int mismatches = 0;
   int tests_run = 0;
   logic [8:0] ofs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
   always #2.5 sys_clk = ~sys_clk;
   dcf_top #(.ADDR_W(4)) i_dcf_top (.*);
   dcf_agent i_dcf_agent (.*);
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Flags for c unread words of 16 with offsets n and m
   task automatic flg(input int c, input int n, input int m);
      chk({empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n},
         {c != 0, c > n, c < 16 - m, c != 16});
   endtask
   task automatic do_reset;
      @(posedge sys_clk) reset_n <= 1'b0;
      threshold_load_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk) threshold_load_n <= 1'b1;
      #1;
   endtask
   task automatic t_reset;
      flg(0, 7, 7);
      chk(read_word, 9'h000);
      chk(expansion_mode, 1'b0);
      @(posedge sys_clk) output_enable_n <= 1'b0;
      @(posedge sys_clk) #1 chk(read_word_oe_n, 1'b0);
      @(posedge sys_clk) output_enable_n <= 1'b1;
      @(posedge sys_clk) #1 chk(read_word_oe_n, 1'b1);
   endtask
   task automatic t_fill;
      for (int i = 0; i < 17; i++) begin
         i_dcf_agent.op(1'b1, 1'b0, 9'(9'h0A0 + i));
         flg(i < 16 ? i + 1 : 16, 7, 7);
      end
   endtask
   task automatic t_drain;
      for (int i = 0; i < 17; i++) begin
         i_dcf_agent.op(1'b0, 1'b1, 9'h000);
         chk(read_word, 9'(9'h0A0 + (i < 16 ? i : 15)));
         flg(i < 16 ? 15 - i : 0, 7, 7);
      end
   endtask
   task automatic t_offsets;
      @(posedge sys_clk) threshold_load_n <= 1'b0;
      for (int i = 0; i < 3; i++) i_dcf_agent.op(1'b1, 1'b0, ofs[i]);
      @(posedge sys_clk) threshold_load_n <= 1'b1;
      @(posedge sys_clk) threshold_load_n <= 1'b0;
      i_dcf_agent.op(1'b1, 1'b0, ofs[3]);
      for (int i = 0; i < 4; i++) begin
         i_dcf_agent.op(1'b0, 1'b1, 9'h000);
         chk(read_word, ofs[i]);
      end
      flg(0, 2, 3);
      @(posedge sys_clk) threshold_load_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         i_dcf_agent.op(1'b1, 1'b0, 9'(9'h0C0 + i));
         flg(i + 1, 2, 3);
      end
   endtask
   task automatic t_replay;
      i_dcf_agent.op(1'b0, 1'b1, 9'h000);
      chk(read_word, 9'h0C0);
      @(posedge sys_clk) replay_strobe <= 1'b1;
      @(posedge sys_clk) replay_strobe <= 1'b0;
      #1 flg(3, 2, 3);
      i_dcf_agent.op(1'b0, 1'b1, 9'h000);
      chk(read_word, 9'h0C0);
   endtask
   // Load high at reset: load and replay lose their meaning
   task automatic t_expand;
      @(posedge sys_clk) reset_n <= 1'b0;
      threshold_load_n <= 1'b1;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk) threshold_load_n <= 1'b0;
      #1 chk(expansion_mode, 1'b1);
      i_dcf_agent.op(1'b1, 1'b0, 9'h155);
      i_dcf_agent.op(1'b1, 1'b0, 9'h0AA);
      flg(2, 7, 7);
      i_dcf_agent.op(1'b0, 1'b1, 9'h000);
      chk(read_word, 9'h155);
      @(posedge sys_clk) replay_strobe <= 1'b1;
      @(posedge sys_clk) replay_strobe <= 1'b0;
      #1 flg(1, 7, 7);
      i_dcf_agent.op(1'b0, 1'b1, 9'h000);
      chk(read_word, 9'h0AA);
   endtask
   initial begin
      repeat (1000) @(posedge sys_clk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      do_reset();
      t_reset();
      t_fill();
      t_drain();
      do_reset();
      t_offsets();
      t_replay();
      t_expand();
      report_and_stop();
   end
endmodule // dual_clock_sync_fifo_flags_tb_top
`default_nettype wire
